//--- logic/scflc_pkg.sv
`default_nettype none
package scflc_pkg;
	// command word layout
	localparam int unsigned CMD_W      = 8;
	localparam int unsigned NIB_W      = 4;
	localparam int unsigned CODE_MSB   = 7;
	localparam int unsigned CODE_LSB   = 5;
	localparam int unsigned GROUP_BIT  = 4;
	localparam int unsigned SEL_W      = 2;

	localparam logic [2:0] CODE_NULL   = 3'h0;
	localparam logic [2:0] CODE_ENABLE = 3'h1;
	localparam logic [2:0] CODE_MODE   = 3'h2;
	localparam logic [2:0] CODE_CLEAR  = 3'h3;
	localparam logic [2:0] CODE_DEAD   = 3'h4;

	// mode command data bits
	localparam int unsigned MODE_LOCK_BIT   = 0;
	localparam int unsigned MODE_BOTHON_BIT = 1;
	localparam int unsigned MODE_DESAT_BIT  = 3;

	// fault latch / status word 0 bit positions
	localparam int unsigned F_OVERTEMP = 0;
	localparam int unsigned F_DESAT    = 1;
	localparam int unsigned F_VLS_UV   = 2;
	localparam int unsigned F_OVERCUR  = 3;
	localparam int unsigned F_PHASE    = 4;
	localparam int unsigned F_FRAME    = 5;
	localparam int unsigned F_WRITE    = 6;
	localparam int unsigned F_RESET    = 7;

	// status word selectors
	localparam logic [1:0] SEL_ST0 = 2'h0;
	localparam logic [1:0] SEL_ST1 = 2'h1;
	localparam logic [1:0] SEL_ST2 = 2'h2;
	localparam logic [1:0] SEL_ST3 = 2'h3;

	// reset values
	localparam logic [3:0] ENABLE_RST = 4'hf;
	localparam logic [7:0] LATCH_RST  = 8'h80;
	localparam logic [2:0] BITCNT_RST = 3'h0;
endpackage
`default_nettype wire

//--- logic/scflc_spi_cmd_fault_latch_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
// Operation
// - command is the last eight bits shifted in during one chip-select frame
// - first three bits are command code, trailing five bits are data
// - bit count not a nonzero multiple of eight flags framing error, message ignored
// - after reset the first transfer returns status word 0
// - null command low two data bits pick status word 0 to 3
// - null command changes no latch, enable or mode state
// - enable commands load lower nibble into enable group a or b
// - clear commands clear latch bits set in the lower nibble, group a or b
// - mode command sets desat mode, both-on mode and lock, returns status 0
// - deadtime command arms calibration and returns status 0
// - enabled latched fault drives interrupt output high
// - faults latch on occurrence and clear only by the matching clear command
// - fault still present keeps interrupt asserted despite a clear
// - returned status shows faults uncleared up to chip-select fall
// - clear acts only when the frame had no framing error
// - fault reported 0 that appears mid-message stays latched
// - clear takes effect at chip-select rising edge ending the command
// - enable, mode, clear and deadtime commands return status word 0
// - during reset only the reset event latch is set, all enable bits are set and the mode bits are cleared
// - group a bits: overtemp, desat, vls undervoltage, overcurrent
// - group b bits: phase error, framing error, write error, reset event
// - lockable write after lock is rejected and raises write error
module scflc_spi_cmd_fault_latch_ctrl
	import scflc_pkg::*;
(
	input  wire logic       clk_i,          // 250 MHz core clock
	input  wire logic       sys_rst_i,      // async reset, active high
	input  wire logic       spi_cs_n_i,     // chip select pin, active low
	input  wire logic       spi_sclk_i,     // spi clock pin
	input  wire logic       spi_si_i,       // serial data in pin
	input  wire logic [3:0] fault_a_i,      // group a fault detector levels
	input  wire logic       phase_err_i,    // phase error detector level
	output logic            spi_so_o,       // serial data out
	output logic            spi_so_oe_o,    // so drive enable, high in frame
	output logic            irq_o,          // interrupt, active high
	output logic            desat_mode_o,   // desat/phase shutdown disabled
	output logic            both_on_mode_o, // both-on mode
	output logic            mode_lock_o,    // lockable registers frozen
	output logic            dt_cal_arm_o    // one-cycle pulse: calibration armed
);
	// pin synchronisers; first stages are read only by second stages
	logic       cs_s1, cs_s2, cs_d;
	logic       sclk_s1, sclk_s2, sclk_d;
	logic       si_s1, si_s2;
	logic [3:0] fa_s1, fa_s2;
	logic       ph_s1, ph_s2;

	always_ff @(posedge clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			cs_s1   <= 1'b1;
			cs_s2   <= 1'b1;
			cs_d    <= 1'b1;
			sclk_s1 <= 1'b0;
			sclk_s2 <= 1'b0;
			sclk_d  <= 1'b0;
			si_s1   <= 1'b0;
			si_s2   <= 1'b0;
			fa_s1   <= 4'h0;
			fa_s2   <= 4'h0;
			ph_s1   <= 1'b0;
			ph_s2   <= 1'b0;
		end
		else
		begin
			cs_s1   <= spi_cs_n_i;
			cs_s2   <= cs_s1;
			cs_d    <= cs_s2;
			sclk_s1 <= spi_sclk_i;
			sclk_s2 <= sclk_s1;
			sclk_d  <= sclk_s2;
			si_s1   <= spi_si_i;
			si_s2   <= si_s1;
			fa_s1   <= fault_a_i;
			fa_s2   <= fa_s1;
			ph_s1   <= phase_err_i;
			ph_s2   <= ph_s1;
		end
	end

	// state
	logic [7:0] rx;
	logic [7:0] tx;
	logic [2:0] bit_cnt;
	logic       any_bits;
	logic [7:0] latch;
	logic [7:0] snap;
	logic [3:0] en_a;
	logic [3:0] en_b;
	logic [1:0] resp_sel;

	function automatic logic [7:0] status_word(
		input logic [1:0] sel,
		input logic [7:0] lat,
		input logic [7:0] ens,
		input logic [7:0] mode,
		input logic [7:0] live
	);
		logic [7:0] w;
		w = lat;
		unique case (sel)
			SEL_ST0: w = lat;
			SEL_ST1: w = ens;
			SEL_ST2: w = mode;
			SEL_ST3: w = live;
		endcase
		return w;
	endfunction

	// edges of the synchronised pins
	wire cs_fall    = cs_d & ~cs_s2;
	wire cs_rise    = ~cs_d & cs_s2;
	wire sclk_rise  = sclk_s2 & ~sclk_d;
	wire sclk_fall  = ~sclk_s2 & sclk_d;
	wire in_frame   = ~cs_s2;

	// command decode of the last eight bits
	wire [2:0] code       = rx[CODE_MSB:CODE_LSB];
	wire [3:0] nib        = rx[NIB_W-1:0];
	wire       grp_b      = rx[GROUP_BIT];
	wire       frame_ok   = any_bits & (bit_cnt == BITCNT_RST);
	wire       act        = cs_rise & frame_ok;
	wire       frame_err  = cs_rise & ~frame_ok;
	wire       is_null    = code == CODE_NULL;
	wire       is_enable  = code == CODE_ENABLE;
	wire       is_mode    = code == CODE_MODE;
	wire       is_clear   = code == CODE_CLEAR;
	wire       is_dead    = code == CODE_DEAD;
	wire       lockable   = act & (is_enable | is_mode | is_dead);
	wire       wr_reject  = lockable & mode_lock_o;
	wire       wr_ok      = act & ~mode_lock_o;

	// clear qualified by what the host was shown at chip-select fall
	wire [7:0] clr_req    = grp_b ? {nib, 4'h0} : {4'h0, nib};
	wire [7:0] clr_bits   = (act & is_clear) ? (clr_req & snap) : 8'h00;
	wire [7:0] set_bits;
	assign set_bits[F_OVERCUR:F_OVERTEMP] = fa_s2;
	assign set_bits[F_PHASE]              = ph_s2;
	assign set_bits[F_FRAME]              = frame_err;
	assign set_bits[F_WRITE]              = wr_reject;
	assign set_bits[F_RESET]              = 1'b0;
	// set wins over clear so a live fault survives its clear command
	wire [7:0] next_latch = (latch & ~clr_bits) | set_bits;

	wire [7:0] ens_word   = {en_b, en_a};
	wire [7:0] mode_word  = {4'h0, desat_mode_o, 1'b0, both_on_mode_o, mode_lock_o};
	wire [7:0] live_word  = {3'h0, ph_s2, fa_s2};
	wire [7:0] out_word   = status_word(resp_sel, latch, ens_word, mode_word, live_word);
	wire [1:0] next_sel   = is_null ? rx[SEL_W-1:0] : SEL_ST0;

	// serial shifting; tx also passes received bits on for daisy chains
	always_ff @(posedge clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			rx          <= 8'h00;
			tx          <= 8'h00;
			bit_cnt     <= BITCNT_RST;
			any_bits    <= 1'b0;
			spi_so_o    <= 1'b0;
			spi_so_oe_o <= 1'b0;
			snap        <= 8'h00;
		end
		else
		begin
			spi_so_oe_o <= in_frame;
			if (cs_fall)
			begin
				tx       <= out_word;
				spi_so_o <= out_word[CMD_W-1];
				snap     <= latch;
				bit_cnt  <= BITCNT_RST;
				any_bits <= 1'b0;
			end
			else if (in_frame & sclk_rise)
			begin
				rx       <= {rx[CMD_W-2:0], si_s2};
				tx       <= {tx[CMD_W-2:0], si_s2};
				bit_cnt  <= bit_cnt + 3'h1;
				any_bits <= 1'b1;
			end
			else if (in_frame & sclk_fall)
			begin
				spi_so_o <= tx[CMD_W-1];
			end
		end
	end

	// latches and programmed registers
	always_ff @(posedge clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			latch          <= LATCH_RST;
			en_a           <= ENABLE_RST;
			en_b           <= ENABLE_RST;
			desat_mode_o   <= 1'b0;
			both_on_mode_o <= 1'b0;
			mode_lock_o    <= 1'b0;
			resp_sel       <= SEL_ST0;
			dt_cal_arm_o   <= 1'b0;
			irq_o          <= 1'b0;
		end
		else
		begin
			latch        <= next_latch;
			irq_o        <= |(latch & ens_word);
			dt_cal_arm_o <= wr_ok & is_dead;
			if (act)
				resp_sel <= next_sel;
			if (wr_ok & is_enable & ~grp_b)
				en_a <= nib;
			if (wr_ok & is_enable & grp_b)
				en_b <= nib;
			if (wr_ok & is_mode)
			begin
				desat_mode_o   <= rx[MODE_DESAT_BIT];
				both_on_mode_o <= rx[MODE_BOTHON_BIT];
				mode_lock_o    <= rx[MODE_LOCK_BIT];
			end
		end
	end

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (sys_rst_i);

	a_irq_follows_latch: assert property (
		(|(latch & ens_word)) |=> irq_o)
		else $error("interrupt not raised for enabled latched fault");

	a_frame_err_flag: assert property (
		frame_err |=> latch[F_FRAME] && $stable(en_a) && $stable(en_b) && $stable(mode_lock_o))
		else $error("bad frame not flagged or not ignored");

	a_null_no_change: assert property (
		act && is_null |=> $stable(en_a) && $stable(en_b) && $stable(mode_word)
			&& ((latch | $past(set_bits)) == ($past(latch) | $past(set_bits))))
		else $error("null command changed state");

	a_enable_load: assert property (
		wr_ok && is_enable && !grp_b |=> en_a == $past(nib))
		else $error("enable group a not loaded");

	a_lock_reject_wr: assert property (
		lockable && mode_lock_o |=> latch[F_WRITE] && $stable(en_a) && $stable(en_b)
			&& $stable(desat_mode_o) && !dt_cal_arm_o)
		else $error("write after lock not rejected");

	a_clear_only_cmd: assert property (
		(|($past(latch) & ~latch)) |-> $past(act && is_clear))
		else $error("latch cleared without clear command");

	a_live_fault_held: assert property (
		(|fa_s2) |=> (latch[F_OVERCUR:F_OVERTEMP] & $past(fa_s2)) == $past(fa_s2))
		else $error("present fault not held in latch");

	a_unseen_kept: assert property (
		act && is_clear |=> ((latch & $past(latch) & ~$past(snap)) == ($past(latch) & ~$past(snap))))
		else $error("unreported fault cleared");

	a_resp_default_st0: assert property (
		act && !is_null |=> resp_sel == SEL_ST0)
		else $error("non-null command did not select status 0");

	a_word_loaded: assert property (
		cs_fall |=> spi_so_o == $past(out_word[CMD_W-1]) && snap == $past(latch))
		else $error("response word not loaded at frame start");

	a_enable_b_load: assert property (
		wr_ok && is_enable && grp_b |=> en_b == $past(nib))
		else $error("enable group b not loaded");

	a_mode_load: assert property (
		wr_ok && is_mode |=> desat_mode_o == $past(rx[MODE_DESAT_BIT])
			&& both_on_mode_o == $past(rx[MODE_BOTHON_BIT])
			&& mode_lock_o == $past(rx[MODE_LOCK_BIT]))
		else $error("mode bits not loaded");

	a_lock_sticky: assert property (
		mode_lock_o |=> mode_lock_o)
		else $error("mode lock dropped without reset");

	a_dt_arm_pulse: assert property (
		dt_cal_arm_o |-> $past(act && is_dead && !mode_lock_o) ##1 !dt_cal_arm_o)
		else $error("calibration arm pulse without accepted command");

	a_clear_applied: assert property (
		act && is_clear |=> (latch & $past(clr_req & snap & ~set_bits)) == 8'h00)
		else $error("reported fault not cleared");

	a_null_select: assert property (
		act && is_null |=> resp_sel == $past(rx[SEL_W-1:0]))
		else $error("null command did not select status word");

	a_bad_frame_keep: assert property (
		frame_err |=> ($past(latch) & ~latch) == 8'h00 && $stable(resp_sel) && !dt_cal_arm_o)
		else $error("bad frame acted on");
endmodule
`default_nettype wire

//--- test/scflc_spi_host.sv
`timescale 1ns/100ps
`default_nettype none
module scflc_spi_host (
	input  wire logic clk_i,  // core clock, paces the host
	output var logic  cs_n_o, // chip select, pull-up level when idle
	output var logic  sclk_o, // mode 0 clock, stands low outside frames
	output var logic  si_o,   // serial data, pull-down level when idle
	input  wire logic so_i,   // device serial data
	input  wire logic so_oe_i // device drives so
);
	int unsigned half_cyc = 10; // raise for a slow host
	initial
	begin
		cs_n_o = 1'b1;
		sclk_o = 1'b0;
		si_o   = 1'b0;
	end
	task automatic tick(input int unsigned n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask
	// pre filler bits stand in for chained parts ahead of us
	task automatic frame(input logic [7:0] cmd, input int unsigned pre, output logic [7:0] resp);
		int unsigned i;
		resp = 8'h00;
		tick(1);
		cs_n_o = 1'b0;
		for (i = 0; i < pre + 8; i++)
		begin
			si_o = (i < pre) ? 1'($urandom) : cmd[7 - (i - pre)];
			tick(half_cyc);
			if (i < 8)
				resp = {resp[6:0], so_oe_i ? so_i : 1'bx};
			sclk_o = 1'b1;
			tick(half_cyc);
			sclk_o = 1'b0;
		end
		tick(half_cyc);
		cs_n_o = 1'b1;
		si_o   = 1'b0;
		tick(half_cyc);
	endtask
endmodule
`default_nettype wire

//--- test/spi_cmd_fault_latch_ctrl_test.sv
`timescale 1ns/100ps
`default_nettype none
module spi_cmd_fault_latch_ctrl_test;
	import scflc_pkg::*;
	logic       clk_i       = 1'b0;
	logic       sys_rst_i   = 1'b1;
	logic [3:0] fault_a_i   = 4'h0;
	logic       phase_err_i = 1'b0;
	wire logic  cs_n, sclk, si, so, so_oe, irq, desat, both_on, lock, dt_arm;
	int         fail_count  = 0;
	int         num_checks  = 0;
	int         dt_seen     = 0;
	int         dt_exp      = 0;
	logic [7:0] lat, en, mode;
	logic [1:0] sel;
	int         i;

	always #2 clk_i = ~clk_i;
	always @(posedge clk_i)
		if (dt_arm === 1'b1)
			dt_seen <= dt_seen + 1;

	scflc_spi_cmd_fault_latch_ctrl dut_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
		.spi_cs_n_i(cs_n), .spi_sclk_i(sclk), .spi_si_i(si), .fault_a_i(fault_a_i),
		.phase_err_i(phase_err_i), .spi_so_o(so), .spi_so_oe_o(so_oe), .irq_o(irq),
		.desat_mode_o(desat), .both_on_mode_o(both_on), .mode_lock_o(lock),
		.dt_cal_arm_o(dt_arm));
	scflc_spi_host host_u (.clk_i(clk_i), .cs_n_o(cs_n), .sclk_o(sclk), .si_o(si),
		.so_i(so), .so_oe_i(so_oe));

	task automatic print_verdict;
		if (fail_count == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		num_checks++;
		if (got !== exp)
		begin
			$display("Error %s expected %h seen %h", what, exp, got);
			fail_count++;
		end
	endtask
	function automatic logic [7:0] status(input logic [1:0] s);
		case (s)
			SEL_ST0: return lat;
			SEL_ST1: return en;
			SEL_ST2: return mode;
			default: return {3'h0, phase_err_i, fault_a_i};
		endcase
	endfunction
	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask
	task automatic settle;
		chk("irq", {7'h0, |(lat & en)}, {7'h0, irq});
		chk("mode", mode, {4'h0, desat, 1'b0, both_on, lock});
		chk("deadtime arm", 8'(dt_exp), 8'(dt_seen));
	endtask
	task automatic reset_dut;
		sys_rst_i = 1'b1;
		tick(4);
		chk("irq in reset", 8'h00, {6'h0, irq, so_oe});
		sys_rst_i = 1'b0;
		lat = LATCH_RST;
		en = {ENABLE_RST, ENABLE_RST};
		mode = 8'h00;
		sel = SEL_ST0;
		tick(3);
		settle;
	endtask
	task automatic send(input logic [7:0] c, input int unsigned pre);
		logic [7:0] exp;
		logic [7:0] snap;
		logic [7:0] r;
		logic [7:0] m;
		exp = status(sel);
		snap = lat;
		host_u.frame(c, pre, r);
		chk("response", exp, r);
		m = c[GROUP_BIT] ? {c[3:0], 4'h0} : {4'h0, c[3:0]};
		if (pre % 8 != 0)
			lat[F_FRAME] = 1'b1;
		else
		begin
			sel = SEL_ST0;
			case (c[CODE_MSB:CODE_LSB])
				CODE_NULL: sel = c[1:0];
				CODE_ENABLE: if (mode[MODE_LOCK_BIT]) lat[F_WRITE] = 1'b1;
					else en = c[GROUP_BIT] ? {c[3:0], en[3:0]} : {en[7:4], c[3:0]};
				CODE_MODE: if (mode[MODE_LOCK_BIT]) lat[F_WRITE] = 1'b1;
					else mode = {4'h0, c[3], 1'b0, c[1], c[0]};
				CODE_CLEAR: lat = (lat & ~(m & snap)) | {3'h0, phase_err_i, fault_a_i};
				CODE_DEAD: if (mode[MODE_LOCK_BIT]) lat[F_WRITE] = 1'b1;
					else dt_exp++;
				default: ;
			endcase
		end
		settle;
	endtask
	task automatic pulse(input logic [3:0] fa, input logic ph);
		fault_a_i = fa;
		phase_err_i = ph;
		tick(4);
		fault_a_i = 4'h0;
		phase_err_i = 1'b0;
		tick(8);
		lat = lat | {3'h0, ph, fa};
		settle;
	endtask

	initial
	begin
		logic [3:0] f;
		void'($urandom(93170));
		reset_dut;
		for (i = 0; i < 4; i++)
			send({3'h0, 3'($urandom), 2'(i + 1)}, 0);
		send(8'h78, 0);
		for (i = 0; i < 5; i++)
		begin
			f = (i < 4) ? 4'(1 << i) : 4'h0;
			pulse(f, i == 4);
			send(8'h00, 0);
			send((i < 4) ? {4'h6, f} : 8'h71, 0);
		end
		f = 4'($urandom);
		send({4'h2, f}, 0);
		send({4'h3, ~f}, 0);
		pulse(4'hf, 1'b1);
		send(8'h01, 0);
		send(8'h6f, 0);
		send(8'h71, 0);
		send(8'h2f, 0);
		send(8'h3f, 0);
		fault_a_i = 4'h1;
		tick(8);
		lat[F_OVERTEMP] = 1'b1;
		send(8'h03, 0);
		send(8'h61, 0);
		fault_a_i = 4'h0;
		send(8'h61, 0);
		fork
			send(8'h62, 0);
			begin
				tick(40);
				fault_a_i = 4'h2;
				tick(10);
				fault_a_i = 4'h0;
				lat[F_DESAT] = 1'b1;
			end
		join
		send(8'h62, 0);
		pulse(4'h4, 1'b0);
		send(8'h64, 3);
		send(8'h64, 0);
		send(8'h72, 0);
		host_u.half_cyc = 25;
		send(8'h01, 8);
		send(8'h00, 16);
		host_u.half_cyc = 10;
		for (i = 5; i < 8; i++)
			send({3'(i), 5'($urandom)}, 0);
		send(8'h81, 0);
		send(8'h42, 0);
		send(8'h48, 0);
		send(8'h4b, 0);
		send(8'h2f, 0);
		send(8'h81, 0);
		send(8'h40, 0);
		send(8'h02, 0);
		send(8'h74, 0);
		send(8'h01, 0);
		reset_dut;
		send(8'h00, 0);
		print_verdict;
	end
	initial
	begin
		repeat (60000) @(posedge clk_i);
		fail_count++;
		print_verdict;
	end
endmodule
`default_nettype wire
